// [rtl/ssbp_consts.svh]
// constants of the synchronous late-write sram port: widths, strap codes, reset values
// assumes it is included by the package and by each design file, by bare name
`ifndef SSBP_CONSTS_SVH
`define SSBP_CONSTS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define SSBP_LANE_W     9
`define SSBP_LANES      4
`define SSBP_DATA_W     36
`define SSBP_ADDR_W     19
`define SSBP_BURST_W    2
`define SSBP_UPPER_W    17
`define SSBP_STRAP_W    3

// ****************************************************************
// strap vector positions inside the synchroniser
// ****************************************************************
`define SSBP_STRAP_SLEEP    2
`define SSBP_STRAP_FLOW_N   1
`define SSBP_STRAP_LINEAR_N 0

// ****************************************************************
// reset values and burst step
// ****************************************************************
`define SSBP_DQ_RST     36'h0_0000_0000
`define SSBP_BURST_ONE  2'h1
`define SSBP_BURST_ZERO 2'h0

`endif

// [rtl/ssbp_pkg.sv]
// types shared by the synchronous late-write sram port
// assumes ssbp_consts.svh is on the include path
`include "ssbp_consts.svh"

package ssbp_pkg;

    // operation carried by the current burst
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } ssbp_op_t;

    // one pending late write
    typedef struct packed {
        logic                       valid;
        logic [`SSBP_ADDR_W-1:0]    addr;
        logic [`SSBP_LANES-1:0]     lanes;
    } ssbp_wr_t;

    // whole state of the port apart from the burst counter and the synchroniser
    typedef struct packed {
        ssbp_wr_t                   wr1;
        ssbp_wr_t                   wr2;
        logic                       rd1;
        logic                       rd2;
        logic [`SSBP_DATA_W-1:0]    dqOut;
        ssbp_op_t                   lastOp;
        logic [`SSBP_UPPER_W-1:0]   upper;
    } ssbp_top_st_t;

    // burst counter state
    typedef struct packed {
        logic [`SSBP_BURST_W-1:0]   preset;
        logic [`SSBP_BURST_W-1:0]   beat;
    } ssbp_burst_st_t;

endpackage : ssbp_pkg

// [rtl/ssbp_sync2.sv]
// two-flop synchroniser for asynchronous level inputs
// assumes a single clock and an asynchronous active-high reset
`timescale 1ns/100ps
`include "ssbp_consts.svh"

module ssbp_sync2
    import ssbp_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           sys_rst,
    // levels
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssbp_sync_st_t;

    ssbp_sync_st_t st_r;
    ssbp_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule : ssbp_sync2

// [rtl/ssbp_burst_ctr.sv]
// four-beat burst counter for the two low address bits
// assumes load and advance come from the same clock domain
`timescale 1ns/100ps
`include "ssbp_consts.svh"

module ssbp_burst_ctr
    import ssbp_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // control
    input  wire logic                       advance,
    input  wire logic                       load,
    input  wire logic                       linear,
    input  wire logic [`SSBP_BURST_W-1:0]   presetIn,
    // low address bits of this access
    output logic      [`SSBP_BURST_W-1:0]   lsbOut
);

    ssbp_burst_st_t st_r;
    ssbp_burst_st_t st_nxt;
    logic [`SSBP_BURST_W-1:0] stepBeat;

    always_comb
    begin
        st_nxt   = st_r;
        stepBeat = st_r.beat + `SSBP_BURST_ONE;
        if (load)
        begin
            lsbOut = presetIn;                                      // R15
        end
        else if (linear)
        begin
            lsbOut = st_r.preset + stepBeat;                        // R17
        end
        else
        begin
            lsbOut = st_r.preset ^ stepBeat;                        // R17
        end
        if (advance)
        begin
            if (load)
            begin
                st_nxt.preset = presetIn;                           // R14
                st_nxt.beat   = `SSBP_BURST_ZERO;
            end
            else
            begin
                st_nxt.beat = stepBeat;                             // R14
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    a_burst_step_one: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        (advance && load) ##1 (advance && !load && $stable(linear))
        |-> lsbOut == (linear ? 2'($past(presetIn) + `SSBP_BURST_ONE)
                              : ($past(presetIn) ^ `SSBP_BURST_ONE)))
        else $error("burst step after load gives wrong low bits");

    a_burst_preset_load: assert property ( // R15
        @(posedge clk) disable iff (sys_rst)
        (advance && load) ##1 (advance && !load)[*3] ##1 (advance && !load && linear)
        |-> lsbOut == $past(presetIn, 4))
        else $error("linear burst does not wrap to preset after four beats");

endmodule : ssbp_burst_ctr

// [rtl/ssbp_top.sv]
// synchronous late-write sram port: command capture, burst, late write, read path
// assumes an external storage array with synchronous read and write ports on clk,
// and a controller whose address, command and data are launched from clk
`timescale 1ns/100ps
`include "ssbp_consts.svh"

// How it works
// (R1) inputs are sampled on the rising clock edge
// (R2) reads and writes interleave without idle cycles
// (R3) write data two cycles late, one in flow-through
// (R4) pipelined read data leaves via output register
// (R5) mode strap low gives flow-through, high pipelined
// (R6) output enable turns drivers off asynchronously
// (R7) sleep input powers down asynchronously
// (R8) writes are started by the clock edge
// (R9) burst-order strap is static: low linear
// (R10) nine-bit byte lanes, each with write control
// (R11) write select low writes, high reads
// (R12) selected only when first low, second high, third low
// (R13) clock gate low lets edges advance state
// (R14) advance/load picks new address or counter step
// (R15) two low address bits preset the counter
// (R16) advance/load high steps, low loads
// (R17) four-beat counter, linear add or interleaved xor
module ssbp_top
    import ssbp_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // address and command
    input  wire logic [`SSBP_UPPER_W-1:0]   addrUpper,
    input  wire logic                       burstPresetLsb0,
    input  wire logic                       burstPresetLsb1,
    input  wire logic                       writeSelect_n,
    input  wire logic                       chipSelectOne_n,
    input  wire logic                       chipSelectTwo,
    input  wire logic                       chipSelectThree_n,
    input  wire logic                       burstStepLoad,
    input  wire logic                       clockGate_n,
    // byte-lane write controls
    input  wire logic                       byteLane0Write_n,
    input  wire logic                       byteLane1Write_n,
    input  wire logic                       byteLane2Write_n,
    input  wire logic                       byteLane3Write_n,
    // asynchronous controls and straps
    input  wire logic                       outputEnable_n,
    input  wire logic                       sleepRequest,
    input  wire logic                       flowThroughSel_n,
    input  wire logic                       linearOrderSel_n,
    // data pins
    input  wire logic [`SSBP_DATA_W-1:0]    dqIn,
    output logic      [`SSBP_DATA_W-1:0]    dqOut,
    output logic                            dqOe,
    // storage array read port
    output logic                            arrRdStb,
    output logic      [`SSBP_ADDR_W-1:0]    arrRdAddr,
    input  wire logic [`SSBP_DATA_W-1:0]    arrRdData,
    // storage array write port
    output logic                            arrWrStb,
    output logic      [`SSBP_ADDR_W-1:0]    arrWrAddr,
    output logic      [`SSBP_DATA_W-1:0]    arrWrData,
    output logic      [`SSBP_LANES-1:0]     arrLaneWe,
    // status
    output logic                            powerDown
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    ssbp_top_st_t               st_r;
    ssbp_top_st_t               st_nxt;
    logic [`SSBP_STRAP_W-1:0]   strapSync;
    logic                       flowMode;
    logic                       linearMode;
    logic                       sleepSync;
    logic                       take;
    logic                       selected;
    logic                       loadNow;
    ssbp_op_t                   opNow;
    logic                       isRead;
    logic                       isWrite;
    logic [`SSBP_BURST_W-1:0]   burstLsb;
    logic [`SSBP_ADDR_W-1:0]    curAddr;
    logic [`SSBP_LANES-1:0]     laneWe;
    ssbp_wr_t                   wrDue;
    logic                       driveSlot;

    // ****************************************************************
    // straps and sleep
    // ****************************************************************
    ssbp_sync2 #(
        .W      (`SSBP_STRAP_W)
    ) u_strap_sync (
        .clk    (clk),
        .sys_rst(sys_rst),
        .d      ({sleepRequest, flowThroughSel_n, linearOrderSel_n}),
        .q      (strapSync)
    );

    assign flowMode   = ~strapSync[`SSBP_STRAP_FLOW_N];             // R5
    assign linearMode = ~strapSync[`SSBP_STRAP_LINEAR_N];           // R9
    assign sleepSync  = strapSync[`SSBP_STRAP_SLEEP];
    assign powerDown  = sleepRequest;                               // R7

    // ****************************************************************
    // command decode
    // ****************************************************************
    assign take     = ~clockGate_n;                                 // R13
    assign selected = ~chipSelectOne_n & chipSelectTwo & ~chipSelectThree_n; // R12
    assign loadNow  = ~burstStepLoad;                               // R16
    assign laneWe   = ~{byteLane3Write_n, byteLane2Write_n,
                        byteLane1Write_n, byteLane0Write_n};        // R10

    always_comb
    begin
        if (sleepSync)
        begin
            opNow = OP_IDLE;                                        // R7
        end
        else if (loadNow)
        begin
            if (!selected)
            begin
                opNow = OP_IDLE;                                    // R12
            end
            else if (writeSelect_n)
            begin
                opNow = OP_READ;                                    // R11
            end
            else
            begin
                opNow = OP_WRITE;                                   // R11
            end
        end
        else
        begin
            opNow = st_r.lastOp;                                    // R14
        end
    end

    assign isRead  = take & (opNow == OP_READ);
    assign isWrite = take & (opNow == OP_WRITE);

    // ****************************************************************
    // burst address
    // ****************************************************************
    ssbp_burst_ctr u_burst (
        .clk     (clk),
        .sys_rst (sys_rst),
        .advance (take),
        .load    (loadNow),
        .linear  (linearMode),
        .presetIn({burstPresetLsb1, burstPresetLsb0}),
        .lsbOut  (burstLsb)
    );

    assign curAddr = {(loadNow ? addrUpper : st_r.upper), burstLsb}; // R15

    // ****************************************************************
    // array ports
    // ****************************************************************
    assign wrDue     = flowMode ? st_r.wr1 : st_r.wr2;              // R3
    assign arrWrStb  = take & wrDue.valid;                          // R8
    assign arrWrAddr = wrDue.addr;
    assign arrWrData = dqIn;                                        // R1
    assign arrLaneWe = arrWrStb ? wrDue.lanes : '0;                 // R10
    assign arrRdStb  = isRead;                                      // R1
    assign arrRdAddr = curAddr;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        if (take)
        begin
            // a new command enters every taken edge whatever the last one was
            st_nxt.wr1.valid = isWrite;                             // R2
            st_nxt.wr1.addr  = curAddr;
            st_nxt.wr1.lanes = laneWe;
            st_nxt.wr2       = st_r.wr1;                            // R3
            st_nxt.rd1       = isRead;                              // R2
            st_nxt.rd2       = st_r.rd1;
            if (st_r.rd1)
            begin
                st_nxt.dqOut = arrRdData;                           // R4
            end
            st_nxt.lastOp = opNow;
            if (loadNow)
            begin
                st_nxt.upper = addrUpper;                           // R14
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;                                         // R1
        end
    end

    // ****************************************************************
    // data pins
    // ****************************************************************
    assign dqOut     = flowMode ? arrRdData : st_r.dqOut;           // R4
    assign driveSlot = flowMode ? st_r.rd1 : st_r.rd2;
    assign dqOe      = driveSlot & ~outputEnable_n & ~sleepRequest; // R6

    // ****************************************************************
    // checks
    // ****************************************************************
    a_pipe_read_reg: assert property ( // R4
        @(posedge clk) disable iff (sys_rst)
        (isRead && !flowMode) ##1 (take && !flowMode)
        |=> st_r.rd2 && st_r.dqOut == $past(arrRdData))
        else $error("pipelined read data not in output register");

    a_flow_read_slot: assert property ( // R5
        @(posedge clk) disable iff (sys_rst)
        (isRead && flowMode) |=> st_r.rd1 && (dqOut == arrRdData)
            && dqOe == (!outputEnable_n && !sleepRequest))
        else $error("flow-through read not driven in next cycle");

    a_flow_late_write: assert property ( // R3
        @(posedge clk) disable iff (sys_rst)
        (isWrite && flowMode) ##1 (take && flowMode)
        |-> arrWrStb && arrWrAddr == $past(curAddr)
            && arrLaneWe == $past(laneWe))
        else $error("single late write not taken one cycle after command");

    a_pipe_late_write: assert property ( // R3
        @(posedge clk) disable iff (sys_rst)
        (isWrite && !flowMode) ##1 (take && !flowMode) ##1 (take && !flowMode)
        |-> arrWrStb && arrWrAddr == $past(curAddr, 2)
            && arrLaneWe == $past(laneWe, 2))
        else $error("double late write not taken two cycles after command");

    a_gate_hold_state: assert property ( // R13
        @(posedge clk) disable iff (sys_rst)
        !take |=> $stable(st_r) ##0 !$past(arrWrStb) && !$past(arrRdStb))
        else $error("state moved on an ignored clock edge");

    a_deselect_idle: assert property ( // R12
        @(posedge clk) disable iff (sys_rst)
        (take && loadNow && (chipSelectOne_n || !chipSelectTwo || chipSelectThree_n))
        |-> !arrRdStb ##1 !st_r.rd1 && !st_r.wr1.valid)
        else $error("deselected device started a cycle");

    a_oe_drivers_off: assert property ( // R6
        @(posedge clk) disable iff (sys_rst)
        (outputEnable_n || sleepRequest) |-> !dqOe)
        else $error("drivers on while output enable off or asleep");

    a_sleep_no_access: assert property ( // R7
        @(posedge clk) disable iff (sys_rst)
        sleepSync |-> !arrRdStb && !isWrite)
        else $error("access started while asleep");

    a_read_write_turn: assert property ( // R2
        @(posedge clk) disable iff (sys_rst)
        (isRead && !flowMode) ##1 isWrite |=> st_r.rd2 && st_r.wr1.valid)
        else $error("write right after read was not accepted");

    a_write_type_sel: assert property ( // R11
        @(posedge clk) disable iff (sys_rst)
        (take && loadNow && selected && !sleepSync)
        |=> st_r.wr1.valid == !$past(writeSelect_n) && st_r.rd1 == $past(writeSelect_n))
        else $error("write select decoded the wrong way");

    a_write_read_turn: assert property ( // R2
        @(posedge clk) disable iff (sys_rst)
        (isWrite && flowMode) ##1 isRead |-> arrWrStb && arrRdStb)
        else $error("read right after write was not accepted");

    a_advance_keeps_upper: assert property ( // R14
        @(posedge clk) disable iff (sys_rst)
        (isRead && loadNow) ##1 (take && !loadNow && !sleepSync)
        |-> isRead && arrRdAddr[`SSBP_ADDR_W-1:`SSBP_BURST_W] == $past(addrUpper))
        else $error("burst read lost its upper address or operation");

endmodule : ssbp_top

// [testbench/ssbp_array_model.sv]
// storage array behind the port: synchronous read that holds, lane-masked write
// assumes strobes, addresses and data come from the port on the same clock
`timescale 1ns/100ps
`include "ssbp_consts.svh"

module ssbp_array_model
    import ssbp_pkg::*;
(
    // clock
    input  wire logic                       clk,
    // read port
    input  wire logic                       rdStb,
    input  wire logic [`SSBP_ADDR_W-1:0]    rdAddr,
    output logic      [`SSBP_DATA_W-1:0]    rdData,
    // write port
    input  wire logic                       wrStb,
    input  wire logic [`SSBP_ADDR_W-1:0]    wrAddr,
    input  wire logic [`SSBP_DATA_W-1:0]    wrData,
    input  wire logic [`SSBP_LANES-1:0]     laneWe
);
    logic [`SSBP_DATA_W-1:0]    mem [logic [`SSBP_ADDR_W-1:0]];
    logic [`SSBP_DATA_W-1:0]    cur;

    initial rdData = `SSBP_DQ_RST;

    // read sees the word as it was before a write at the same edge
    always @(posedge clk)
    begin
        if (rdStb)
            rdData <= mem.exists(rdAddr) ? mem[rdAddr] : `SSBP_DQ_RST;
        if (wrStb)
        begin
            cur = mem.exists(wrAddr) ? mem[wrAddr] : `SSBP_DQ_RST;
            for (int k = 0; k < `SSBP_LANES; k++)
                if (laneWe[k])
                    cur[k*`SSBP_LANE_W +: `SSBP_LANE_W] = wrData[k*`SSBP_LANE_W +: `SSBP_LANE_W];
            mem[wrAddr] = cur;
        end
    end
endmodule : ssbp_array_model

// [testbench/sync_sram_bus_port_tb.sv]
// self-checking bench of the late-write sram port in all four strap settings
// assumes ssbp_top and the array model; the bench acts as the memory controller
`timescale 1ns/100ps
`include "ssbp_consts.svh"

module sync_sram_bus_port_tb
    import ssbp_pkg::*;
;
    logic                       clk;
    logic                       sysRst;
    logic [`SSBP_UPPER_W-1:0]   addrUpper;
    logic                       lsb0;
    logic                       lsb1;
    logic                       weN;
    logic                       cs1N;
    logic                       cs2;
    logic                       cs3N;
    logic                       stepLoad;
    logic                       gateN;
    logic [`SSBP_LANES-1:0]     laneN;
    logic                       oeN;
    logic                       sleep;
    logic                       flowN;
    logic                       linN;
    logic [`SSBP_DATA_W-1:0]    dqIn;
    logic [`SSBP_DATA_W-1:0]    dqOut;
    logic                       dqOe;
    logic                       arrRdStb;
    logic [`SSBP_ADDR_W-1:0]    arrRdAddr;
    logic [`SSBP_DATA_W-1:0]    arrRdData;
    logic                       arrWrStb;
    logic [`SSBP_ADDR_W-1:0]    arrWrAddr;
    logic [`SSBP_DATA_W-1:0]    arrWrData;
    logic [`SSBP_LANES-1:0]     arrLaneWe;
    logic                       powerDown;
    int                         nFail;
    int                         samplesChecked;
    // reference of the expected behaviour, advanced on taken edges only
    logic [`SSBP_DATA_W-1:0]    mem [16] = '{default: 36'h0};
    logic                       outV;
    logic [`SSBP_DATA_W-1:0]    outD;
    logic                       pRdV;
    logic [`SSBP_DATA_W-1:0]    pRdD;
    logic                       w1V;
    logic                       w2V;
    logic [`SSBP_ADDR_W-1:0]    w1A;
    logic [`SSBP_ADDR_W-1:0]    w2A;
    logic [`SSBP_LANES-1:0]     w1L;
    logic [`SSBP_LANES-1:0]     w2L;
    ssbp_op_t                   lastOp;
    logic [1:0]                 preset;
    logic [1:0]                 beat;
    logic [`SSBP_UPPER_W-1:0]   upr;
    // sleep pin as the port's synchroniser sees it, oldest stage on top
    logic [2:0]                 slp;

    ssbp_top i_dut (
        .clk(clk), .sys_rst(sysRst), .addrUpper(addrUpper),
        .burstPresetLsb0(lsb0), .burstPresetLsb1(lsb1), .writeSelect_n(weN),
        .chipSelectOne_n(cs1N), .chipSelectTwo(cs2), .chipSelectThree_n(cs3N),
        .burstStepLoad(stepLoad), .clockGate_n(gateN),
        .byteLane0Write_n(laneN[0]), .byteLane1Write_n(laneN[1]),
        .byteLane2Write_n(laneN[2]), .byteLane3Write_n(laneN[3]),
        .outputEnable_n(oeN), .sleepRequest(sleep), .flowThroughSel_n(flowN),
        .linearOrderSel_n(linN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .arrRdStb(arrRdStb), .arrRdAddr(arrRdAddr), .arrRdData(arrRdData),
        .arrWrStb(arrWrStb), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData),
        .arrLaneWe(arrLaneWe), .powerDown(powerDown)
    );

    ssbp_array_model i_array (
        .clk(clk), .rdStb(arrRdStb), .rdAddr(arrRdAddr), .rdData(arrRdData),
        .wrStb(arrWrStb), .wrAddr(arrWrAddr), .wrData(arrWrData), .laneWe(arrLaneWe)
    );

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            nFail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic endOfTest;
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : endOfTest

    // ****************************************************************
    // one clock cycle of controller traffic; ax below zero picks a random address
    // ****************************************************************
    task automatic step(input logic g, a, s, w, sl, oe, input int ax);
        logic [2:0]                 r;
        logic [`SSBP_ADDR_W-1:0]    ad;
        logic [`SSBP_DATA_W-1:0]    rd;
        logic                       dV;
        logic [`SSBP_ADDR_W-1:0]    dA;
        logic [`SSBP_LANES-1:0]     dL;
        ssbp_op_t                   op;
        r = s ? 3'h0 : 3'(1 + $urandom % 7);
        @(posedge clk);
        gateN <= g;
        stepLoad <= a;
        cs1N <= r[0];
        cs2 <= ~r[1];
        cs3N <= r[2];
        weN <= ~w;
        addrUpper <= 17'(ax < 0 ? 2'($urandom) : 2'(ax >> 2));
        {lsb1, lsb0} <= ax < 0 ? 2'($urandom) : 2'(ax);
        laneN <= 4'($urandom);
        dqIn <= {4'($urandom), $urandom};
        oeN <= oe;
        sleep <= sl;
        #1;
        dV = flowN ? w2V : w1V;
        dA = flowN ? w2A : w1A;
        dL = flowN ? w2L : w1L;
        check("powerDown", powerDown, sleep);
        check("dqOe", dqOe, outV & ~oeN & ~sleep);
        if (outV & ~oeN & ~sleep)
            check("dqOut", dqOut, outD);
        slp = {slp[1:0], sleep};
        if (gateN)
            return;
        op = lastOp;
        beat = beat + 2'h1;
        if (!stepLoad)
        begin
            op = (cs1N | ~cs2 | cs3N) ? OP_IDLE : (weN ? OP_READ : OP_WRITE);
            preset = {lsb1, lsb0};
            beat = 2'h0;
            upr = addrUpper;
        end
        if (slp[2])
            op = OP_IDLE;
        lastOp = op;
        ad = {upr, linN ? preset ^ beat : preset + beat};
        check("arrRdStb", arrRdStb, op == OP_READ);
        if (op == OP_READ)
            check("arrRdAddr", arrRdAddr, ad);
        check("arrWrStb", arrWrStb, dV);
        check("arrLaneWe", arrLaneWe, dV ? 4'(~dL) : 4'h0);
        if (dV)
        begin
            check("arrWrAddr", arrWrAddr, dA);
            check("arrWrData", arrWrData, dqIn);
        end
        rd = mem[ad[3:0]];
        for (int k = 0; k < `SSBP_LANES; k++)
            if (dV & ~dL[k])
                mem[dA[3:0]][k*`SSBP_LANE_W +: `SSBP_LANE_W] = dqIn[k*`SSBP_LANE_W +: `SSBP_LANE_W];
        w2V = w1V;
        w2A = w1A;
        w2L = w1L;
        w1V = op == OP_WRITE;
        w1A = ad;
        w1L = laneN;
        outV = flowN ? pRdV : op == OP_READ;
        outD = flowN ? pRdD : rd;
        pRdV = op == OP_READ;
        pRdD = rd;
    endtask : step

    // ****************************************************************
    // one strap setting: reset, burst corner case, sleep, random traffic
    // ****************************************************************
    task automatic runMode(input logic f, input logic l);
        @(posedge clk);
        sysRst <= 1'b1;
        stepLoad <= 1'b0;
        cs1N <= 1'b1;
        gateN <= 1'b0;
        sleep <= 1'b0;
        oeN <= 1'b0;
        flowN <= f;
        linN <= l;
        repeat (10) @(posedge clk);
        sysRst <= 1'b0;
        outV = 1'b0;
        pRdV = 1'b0;
        w1V = 1'b0;
        w2V = 1'b0;
        lastOp = OP_IDLE;
        slp = 3'h0;
        beat = 2'h0;
        repeat (4) step(0, 0, 0, 0, 0, 0, -1);
        // write burst of five beats wraps onto its start, then read it back at once
        for (int i = 0; i < 10; i++)
            step(0, i % 5 != 0, 1, i < 5, 0, 0, 6);
        for (int i = 0; i < 7; i++)
            step(0, 0, 1, $urandom % 2, i < 4, 0, -1);
        repeat (250)
            step($urandom % 8 == 0, $urandom % 3 == 0, $urandom % 6 != 0, $urandom % 2, 0,
                 $urandom % 10 == 0, -1);
    endtask : runMode

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        #100000;
        nFail++;
        $display("ERROR watchdog expected done seen running");
        endOfTest();
    end

    initial
    begin
        sysRst = 1'b1;
        {gateN, stepLoad, cs2, lsb0, lsb1, oeN, sleep, flowN, linN} = 9'h0;
        {cs1N, cs3N, weN} = 3'h7;
        addrUpper = 17'h0;
        laneN = 4'hf;
        dqIn = 36'h0;
        nFail = 0;
        samplesChecked = 0;
        void'($urandom(32'hdf82));
        for (int m = 0; m < 4; m++)
            runMode(m[0], m[1]);
        endOfTest();
    end
endmodule : sync_sram_bus_port_tb
